// file: cvr_pkg.sv
package cvr_pkg;
    // code field layout shared by every voltage register
    localparam int CODE_W = 7;
    localparam int CODE_LSB = 1;
    localparam int CODE_MSB = 7;
    localparam int DISCH_BIT = 0;
    localparam int RAILS = 3;

    // rail slots inside the bank
    localparam int RAIL_C4 = 0;
    localparam int RAIL_C5 = 1;
    localparam int RAIL_C6 = 2;

    // register byte offsets on the register port
    localparam logic [7:0] ADDR_C4_SLEEP = 8'h95;
    localparam logic [7:0] ADDR_C5_NORMAL = 8'h96;
    localparam logic [7:0] ADDR_C5_SLEEP = 8'h97;
    localparam logic [7:0] ADDR_C6_NORMAL = 8'h98;
    localparam logic [7:0] ADDR_C6_SLEEP = 8'h99;

    // values after reset; real parts load these from configuration
    localparam logic [7:0] RST_C4_SLEEP = 8'h00;
    localparam logic [7:0] RST_C5_NORMAL = 8'h00;
    localparam logic [7:0] RST_C5_SLEEP = 8'h00;
    localparam logic [7:0] RST_C6_NORMAL = 8'h00;
    localparam logic [7:0] RST_C6_SLEEP = 8'h00;

    localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage : cvr_pkg

// file: cvr_rail_if.sv
`timescale 1ns/1ps
interface cvr_rail_if;
    // settings handed to one converter's selector
    logic [cvr_pkg::CODE_W-1:0] normal_code;
    logic [cvr_pkg::CODE_W-1:0] sleep_code;
    logic passive;
    logic use_sleep;
    // what the selector reports back
    logic [cvr_pkg::CODE_W-1:0] target_code;
    logic slew_down;
    logic decay_down;
    logic in_sleep;

    modport bank (output normal_code, sleep_code, passive, use_sleep,
                  input target_code, slew_down, decay_down, in_sleep);
    modport rail (input normal_code, sleep_code, passive, use_sleep,
                  output target_code, slew_down, decay_down, in_sleep);
endinterface : cvr_rail_if

// file: cvr_rail_sel.sv
`timescale 1ns/1ps
module cvr_rail_sel (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // converter settings and results
    cvr_rail_if.rail rail
);
    logic [cvr_pkg::CODE_W-1:0] sel_code;
    logic [cvr_pkg::CODE_W-1:0] target_r;
    logic slew_r;
    logic decay_r;
    logic in_sleep_r;

    // sleep code wins only while sleep is enabled and its pin is low
    assign sel_code = rail.use_sleep ? rail.sleep_code : rail.normal_code;

    // target follows the chosen code one cycle later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            target_r <= '0;
            in_sleep_r <= 1'b0;
        end else begin
            target_r <= sel_code;
            in_sleep_r <= rail.use_sleep;
        end
    end

    // a lower target picks active slew or passive decay, one-cycle pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slew_r <= 1'b0;
            decay_r <= 1'b0;
        end else begin
            slew_r <= (sel_code < target_r) && !rail.passive;
            decay_r <= (sel_code < target_r) && rail.passive;
        end
    end

    assign rail.target_code = target_r;
    assign rail.slew_down = slew_r;
    assign rail.decay_down = decay_r;
    assign rail.in_sleep = in_sleep_r;
endmodule // cvr_rail_sel

// file: cvr_regs.sv
// Function
// - converter five normal target comes from bits 7:1, 25 mV steps
// - lowering converter five or six: bit0 zero slews actively, one decays passively
// - converter five sleep target comes from bits 7:1, 25 mV steps
// - converter six normal target from bits 7:1, 10 mV or 25 mV steps
// - converter six sleep target from bits 7:1, 10 mV or 25 mV steps
// - converter four sleep target comes from bits 7:1, 25 mV steps
// - sleep code applies only when sleep enabled and assigned pin low
`timescale 1ns/1ps
module cvr_regs (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // converter four settings held outside this bank
    input wire logic [cvr_pkg::CODE_W-1:0] CONV4_NORMAL_CODE,
    input wire logic CONV4_PASSIVE,
    // sleep configuration, index 0 = converter four
    input wire logic [cvr_pkg::RAILS-1:0] SLEEP_EN,
    input wire logic [cvr_pkg::RAILS-1:0] SLEEP_PIN_SEL,
    input wire logic SLEEP_PIN_A_N,
    input wire logic SLEEP_PIN_B_N,
    // converter six step range select, 1 = 10 mV steps
    input wire logic CONV6_RANGE_10MV,
    // converter targets and ramp events
    output logic [cvr_pkg::RAILS-1:0][cvr_pkg::CODE_W-1:0] TARGET_CODE,
    output logic [cvr_pkg::RAILS-1:0] SLEW_DOWN,
    output logic [cvr_pkg::RAILS-1:0] DECAY_DOWN,
    output logic [cvr_pkg::RAILS-1:0] IN_SLEEP,
    output logic CONV6_STEP_10MV
);
    logic [cvr_pkg::CODE_W-1:0] c4_sleep_r;
    logic [cvr_pkg::CODE_W-1:0] c5_normal_r;
    logic c5_passive_r;
    logic [cvr_pkg::CODE_W-1:0] c5_sleep_r;
    logic [cvr_pkg::CODE_W-1:0] c6_normal_r;
    logic c6_passive_r;
    logic [cvr_pkg::CODE_W-1:0] c6_sleep_r;
    logic [1:0] pin_a_sync_r;
    logic [1:0] pin_b_sync_r;
    logic [7:0] rdata_r;
    logic range_r;
    logic [cvr_pkg::RAILS-1:0][cvr_pkg::CODE_W-1:0] normal_code;
    logic [cvr_pkg::RAILS-1:0][cvr_pkg::CODE_W-1:0] sleep_code;
    logic [cvr_pkg::RAILS-1:0] passive;

    // write strobe for one offset
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] offs);
        hit = REG_WR && (addr == offs);
    endfunction

    // sleep pins are asynchronous; two flops before anything looks at them
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_a_sync_r <= 2'h3;
            pin_b_sync_r <= 2'h3;
        end else begin
            pin_a_sync_r <= {pin_a_sync_r[0], SLEEP_PIN_A_N};
            pin_b_sync_r <= {pin_b_sync_r[0], SLEEP_PIN_B_N};
        end
    end

    // converter four sleep code; bit 0 is not stored
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            c4_sleep_r <= cvr_pkg::RST_C4_SLEEP[cvr_pkg::CODE_MSB:cvr_pkg::CODE_LSB];
        end else if (hit(REG_ADDR, cvr_pkg::ADDR_C4_SLEEP)) begin
            c4_sleep_r <= REG_WDATA[cvr_pkg::CODE_MSB:cvr_pkg::CODE_LSB];
        end
    end

    // converter five normal code and discharge style
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            c5_normal_r <= cvr_pkg::RST_C5_NORMAL[cvr_pkg::CODE_MSB:cvr_pkg::CODE_LSB];
            c5_passive_r <= cvr_pkg::RST_C5_NORMAL[cvr_pkg::DISCH_BIT];
        end else if (hit(REG_ADDR, cvr_pkg::ADDR_C5_NORMAL)) begin
            c5_normal_r <= REG_WDATA[cvr_pkg::CODE_MSB:cvr_pkg::CODE_LSB];
            c5_passive_r <= REG_WDATA[cvr_pkg::DISCH_BIT];
        end
    end

    // converter five sleep code
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            c5_sleep_r <= cvr_pkg::RST_C5_SLEEP[cvr_pkg::CODE_MSB:cvr_pkg::CODE_LSB];
        end else if (hit(REG_ADDR, cvr_pkg::ADDR_C5_SLEEP)) begin
            c5_sleep_r <= REG_WDATA[cvr_pkg::CODE_MSB:cvr_pkg::CODE_LSB];
        end
    end

    // converter six normal code and discharge style
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            c6_normal_r <= cvr_pkg::RST_C6_NORMAL[cvr_pkg::CODE_MSB:cvr_pkg::CODE_LSB];
            c6_passive_r <= cvr_pkg::RST_C6_NORMAL[cvr_pkg::DISCH_BIT];
        end else if (hit(REG_ADDR, cvr_pkg::ADDR_C6_NORMAL)) begin
            c6_normal_r <= REG_WDATA[cvr_pkg::CODE_MSB:cvr_pkg::CODE_LSB];
            c6_passive_r <= REG_WDATA[cvr_pkg::DISCH_BIT];
        end
    end

    // converter six sleep code
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            c6_sleep_r <= cvr_pkg::RST_C6_SLEEP[cvr_pkg::CODE_MSB:cvr_pkg::CODE_LSB];
        end else if (hit(REG_ADDR, cvr_pkg::ADDR_C6_SLEEP)) begin
            c6_sleep_r <= REG_WDATA[cvr_pkg::CODE_MSB:cvr_pkg::CODE_LSB];
        end
    end

    // step range takes one flop, so it changes one edge ahead of a target set by a write in the same cycle
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            range_r <= 1'b0;
        end else begin
            range_r <= CONV6_RANGE_10MV;
        end
    end

    // read data registered on a read strobe; unmapped offsets read zero
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_r <= cvr_pkg::READ_UNMAPPED;
        end else if (REG_RD) begin
            if (REG_ADDR == cvr_pkg::ADDR_C4_SLEEP) begin
                rdata_r <= {c4_sleep_r, 1'b0};
            end else if (REG_ADDR == cvr_pkg::ADDR_C5_NORMAL) begin
                rdata_r <= {c5_normal_r, c5_passive_r};
            end else if (REG_ADDR == cvr_pkg::ADDR_C5_SLEEP) begin
                rdata_r <= {c5_sleep_r, 1'b0};
            end else if (REG_ADDR == cvr_pkg::ADDR_C6_NORMAL) begin
                rdata_r <= {c6_normal_r, c6_passive_r};
            end else if (REG_ADDR == cvr_pkg::ADDR_C6_SLEEP) begin
                rdata_r <= {c6_sleep_r, 1'b0};
            end else begin
                rdata_r <= cvr_pkg::READ_UNMAPPED;
            end
        end
    end

    // gather per-rail settings so one generate loop serves all three
    assign normal_code[cvr_pkg::RAIL_C4] = CONV4_NORMAL_CODE;
    assign normal_code[cvr_pkg::RAIL_C5] = c5_normal_r;
    assign normal_code[cvr_pkg::RAIL_C6] = c6_normal_r;
    assign sleep_code[cvr_pkg::RAIL_C4] = c4_sleep_r;
    assign sleep_code[cvr_pkg::RAIL_C5] = c5_sleep_r;
    assign sleep_code[cvr_pkg::RAIL_C6] = c6_sleep_r;
    assign passive[cvr_pkg::RAIL_C4] = CONV4_PASSIVE;
    assign passive[cvr_pkg::RAIL_C5] = c5_passive_r;
    assign passive[cvr_pkg::RAIL_C6] = c6_passive_r;

    cvr_rail_if rail_bus[cvr_pkg::RAILS] ();

    // one selector per converter
    for (genvar g = 0; g < cvr_pkg::RAILS; g++) begin : g_rail
        logic pin_low;
        // assigned pin is active low; read only from the second sync flop
        assign pin_low = SLEEP_PIN_SEL[g] ? !pin_b_sync_r[1] : !pin_a_sync_r[1];
        assign rail_bus[g].normal_code = normal_code[g];
        assign rail_bus[g].sleep_code = sleep_code[g];
        assign rail_bus[g].passive = passive[g];
        assign rail_bus[g].use_sleep = SLEEP_EN[g] && pin_low;
        cvr_rail_sel u_sel (
            .clk(CORE_CLK),
            .rst_n(RESET_N),
            .rail(rail_bus[g])
        );
        assign TARGET_CODE[g] = rail_bus[g].target_code;
        assign SLEW_DOWN[g] = rail_bus[g].slew_down;
        assign DECAY_DOWN[g] = rail_bus[g].decay_down;
        assign IN_SLEEP[g] = rail_bus[g].in_sleep;
    end

    assign REG_RDATA = rdata_r;
    assign CONV6_STEP_10MV = range_r;
endmodule // cvr_regs

// file: cvr_regs_props.sv
`timescale 1ns/1ps
module cvr_regs_props (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    // sleep controls and rail results
    input wire logic [2:0] SLEEP_EN,
    input wire logic [2:0] SLEEP_PIN_SEL,
    input wire logic SLEEP_PIN_A_N,
    input wire logic [2:0][6:0] TARGET_CODE,
    input wire logic [2:0] SLEW_DOWN,
    input wire logic [2:0] DECAY_DOWN,
    input wire logic [2:0] IN_SLEEP
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);
    // write, then one cycle without a rewrite, with the rail's sleep choice held through both cycles after the write
    sequence s_wr(logic [7:0] a, int i, logic s);
        REG_WR && REG_ADDR == a && IN_SLEEP[i] == s ##1 IN_SLEEP[i] == s && !(REG_WR && REG_ADDR == a)
        ##1 IN_SLEEP[i] == s;
    endsequence
    property p_code(logic [7:0] a, int i, logic s);
        s_wr(a, i, s) |-> TARGET_CODE[i] == $past(REG_WDATA[7:1], 2);
    endproperty
    // a pulse comes exactly when the target falls, never both kinds
    property p_drop(int i);
        (SLEW_DOWN[i] || DECAY_DOWN[i]) == (TARGET_CODE[i] < $past(TARGET_CODE[i]))
            && !(SLEW_DOWN[i] && DECAY_DOWN[i]);
    endproperty
    // a read of any sleep register returns zero in bit 0 on the next edge
    property p_bit0;
        REG_RD && REG_ADDR[0] && REG_ADDR inside {[cvr_pkg::ADDR_C4_SLEEP:cvr_pkg::ADDR_C6_SLEEP]} |=> !REG_RDATA[0];
    endproperty
    sequence s_pin_low;
        (SLEEP_EN[1] && !SLEEP_PIN_SEL[1] && !SLEEP_PIN_A_N) [*4];
    endsequence
    AST_C5_NORMAL: assert property (p_code(cvr_pkg::ADDR_C5_NORMAL, 1, 1'b0)) else $error("conv5 normal target");
    AST_C5_SLEEP: assert property (p_code(cvr_pkg::ADDR_C5_SLEEP, 1, 1'b1)) else $error("conv5 sleep target");
    AST_C6_NORMAL: assert property (p_code(cvr_pkg::ADDR_C6_NORMAL, 2, 1'b0)) else $error("conv6 normal target");
    AST_C6_SLEEP: assert property (p_code(cvr_pkg::ADDR_C6_SLEEP, 2, 1'b1)) else $error("conv6 sleep target");
    AST_C4_SLEEP: assert property (p_code(cvr_pkg::ADDR_C4_SLEEP, 0, 1'b1)) else $error("conv4 sleep target");
    AST_C5_DROP: assert property (p_drop(1)) else $error("conv5 ramp pulse");
    AST_C6_DROP: assert property (p_drop(2)) else $error("conv6 ramp pulse");
    AST_SLEEP_GATED: assert property ((IN_SLEEP & ~$past(SLEEP_EN)) == 3'h0) else $error("sleep without enable");
    AST_PIN_ENTRY: assert property (s_pin_low |-> IN_SLEEP[1]) else $error("sleep entry late");
    AST_SLEEP_BIT0: assert property (p_bit0) else $error("sleep bit0 set");
endmodule // cvr_regs_props

// file: cvr_regs_tb.sv
`timescale 1ns/1ps
module cvr_regs_tb;
    logic CORE_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [7:0] REG_WDATA = 8'h00;
    logic [7:0] REG_RDATA;
    logic [6:0] CONV4_NORMAL_CODE = 7'h00;
    logic CONV4_PASSIVE = 1'b0;
    logic [2:0] SLEEP_EN = 3'h0;
    logic [2:0] SLEEP_PIN_SEL = 3'h0;
    logic SLEEP_PIN_A_N = 1'b1;
    logic SLEEP_PIN_B_N = 1'b1;
    logic CONV6_RANGE_10MV = 1'b0;
    logic [2:0][6:0] TARGET_CODE;
    logic [2:0] SLEW_DOWN, DECAY_DOWN, IN_SLEEP;
    logic CONV6_STEP_10MV;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int seed = 32'hF9F6FB8A;
    int r, ns, nd;
    logic [7:0] a;
    logic [7:0] m [5] = '{default: 8'h00}; // bench copy of the bank, index = offset - 0x95

    cvr_regs DUT (.CORE_CLK, .RESET_N, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA, .CONV4_NORMAL_CODE,
        .CONV4_PASSIVE, .SLEEP_EN, .SLEEP_PIN_SEL, .SLEEP_PIN_A_N, .SLEEP_PIN_B_N, .CONV6_RANGE_10MV, .TARGET_CODE,
        .SLEW_DOWN, .DECAY_DOWN, .IN_SLEEP, .CONV6_STEP_10MV);

    // 40 MHz clock and a hang guard far above the ~400 cycles used
    always #12.5 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic inr(input logic [7:0] ad);
        return ad >= cvr_pkg::ADDR_C4_SLEEP && ad <= cvr_pkg::ADDR_C6_SLEEP;
    endfunction
    // sleep choice of rail i as the model sees the inputs
    function automatic logic sel(input int i);
        return SLEEP_EN[i] && !(SLEEP_PIN_SEL[i] ? SLEEP_PIN_B_N : SLEEP_PIN_A_N);
    endfunction
    function automatic logic [6:0] texp(input int i);
        if (sel(i)) return m[2 * i][7:1];
        return (i == 0) ? CONV4_NORMAL_CODE : m[2 * i - 1][7:1];
    endfunction
    // sleep registers are the odd offsets; their bit 0 never sticks
    // an edge passes first so a strobe lowered by the last call is never raised in the same step
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge CORE_CLK);
        #2;
        REG_ADDR = ad;
        REG_WDATA = d;
        REG_WR = 1'b1;
        @(posedge CORE_CLK);
        #2;
        REG_WR = 1'b0;
        if (inr(ad)) m[ad - cvr_pkg::ADDR_C4_SLEEP] = ad[0] ? {d[7:1], 1'b0} : d;
    endtask
    task automatic rd(input logic [7:0] ad);
        @(posedge CORE_CLK);
        #2;
        REG_ADDR = ad;
        REG_RD = 1'b1;
        @(posedge CORE_CLK);
        #2;
        REG_RD = 1'b0;
        chk("rdata", inr(ad) ? m[ad - cvr_pkg::ADDR_C4_SLEEP] : cvr_pkg::READ_UNMAPPED, REG_RDATA);
    endtask
    // four edges cover the two sync flops plus the select stage
    task automatic settle();
        repeat (4) @(posedge CORE_CLK);
        #2;
        for (int i = 0; i < 3; i++) begin
            chk("target", {1'b0, texp(i)}, {1'b0, TARGET_CODE[i]});
            chk("in_sleep", {7'h00, sel(i)}, {7'h00, IN_SLEEP[i]});
        end
        chk("step10", {7'h00, CONV6_RANGE_10MV}, {7'h00, CONV6_STEP_10MV});
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // reset, random traffic, ramp-down styles, then a reset in mid-run
    initial begin
        repeat (2) @(posedge CORE_CLK);
        #2;
        RESET_N = 1'b1;
        for (int k = 0; k < 7; k++) rd(8'h94 + k[7:0]);
        for (int n = 0; n < 40; n++) begin
            r = $random(seed);
            a = 8'h94 + {5'h00, r[2:0]};
            wr(a, r[10:3]);
            rd(a);
            {SLEEP_EN, SLEEP_PIN_SEL, SLEEP_PIN_A_N, SLEEP_PIN_B_N, CONV6_RANGE_10MV, CONV4_PASSIVE,
                CONV4_NORMAL_CODE} = r[31:15];
            settle();
        end
        SLEEP_EN = 3'h0;
        for (int k = 0; k < 4; k++) begin
            a = cvr_pkg::ADDR_C5_NORMAL + {6'h00, k[1], 1'b0};
            wr(a, {7'h60, k[0]});
            settle();
            wr(a, {7'h10, k[0]});
            ns = 0;
            nd = 0;
            repeat (4) begin
                @(posedge CORE_CLK);
                #2;
                ns += SLEW_DOWN[1 + k[1]];
                nd += DECAY_DOWN[1 + k[1]];
            end
            chk("slew", {7'h00, !k[0]}, ns[7:0]);
            chk("decay", {7'h00, k[0]}, nd[7:0]);
        end
        RESET_N = 1'b0;
        @(posedge CORE_CLK);
        #2;
        RESET_N = 1'b1;
        m = '{default: 8'h00};
        for (int k = 0; k < 7; k++) rd(8'h94 + k[7:0]);
        settle();
        end_sim();
    end
endmodule // cvr_regs_tb

bind cvr_regs cvr_regs_props u_props (.CORE_CLK, .RESET_N, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA,
    .SLEEP_EN, .SLEEP_PIN_SEL, .SLEEP_PIN_A_N, .TARGET_CODE, .SLEW_DOWN, .DECAY_DOWN, .IN_SLEEP);
